// file: rtac_alarm_supply.v
// Purpose: dual alarm, event mask, supply enable and scratch registers
// Assumes: calendar counters supplied by calendar logic on clk_sys
// Notes:   tick pulses on each counted second, from calendar logic
// Behaviour
// - Each alarm has six match fields, each with its own enable bit.
// - Match fields are BCD; widths seven, seven, six, three, six, four bits.
// - Six-bit hour follows calendar mode; bit five is PM in 12-hour.
// - Master enable off never fires; on with no fields fires per second.
// - Two independent alarms, each with its own request.
// - Year is never compared by either alarm.
// - Alarm request serves as wake from sleep, deep sleep, hibernate.
// - Hibernate wake from alarm needs the power controller wake gate.
// - Mask holds bits for first alarm, second alarm and century.
// - Supply enable output is active high on the supply pin.
// - Supply enable clears only while unlock byte holds 0x3A.
// - Drive bit zero floats the pin only while the key is present.
// - Force-on bit holds enable and sticks until domain reset.
// - Enable resets to one, clears only with earlier key and no force.
// - After clearing, software may set the enable again.
// - Alarm or century event sets the supply enable again.
// - High wake request pin sets the supply enable again.
// - Eight retained 32-bit scratch registers.
// - Read bit freezes live values; refused while busy or writing.
// - Writes taken only while write bit set; clear copies at once.
// - Century event when year wraps from 99 to 00.
// - Only power loss or domain reset field clears domain state.
//
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "rtac_consts.vh"
module rtac_alarm_supply
(
  // Clock and domain reset
  input  wire        clk_sys,
  input  wire        rstn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Calendar side
  input  wire        secTick,
  input  wire [31:0] liveTime,
  input  wire [31:0] liveDate,
  input  wire        calBusy,
  output reg  [31:0] loadTime,
  output reg  [31:0] loadDate,
  output reg         loadStrobe,
  // Pins and wake
  input  wire        wakeRequestPin,
  input  wire        hibernateAlarmWakeGate,
  output reg         supplyEnablePinOut,
  output reg         supplyEnablePinOe,
  output reg         domainIrq,
  output reg         hibernateWake,
  output reg         domainResetReq
);

  reg  [31:0] ctrl_reg;
  reg  [31:0] frzTime_reg;
  reg  [31:0] frzDate_reg;
  reg  [31:0] usrTime_reg;
  reg  [31:0] usrDate_reg;
  reg  [31:0] almTime_reg [0:1];
  reg  [31:0] almDate_reg [0:1];
  reg  [31:0] scratch_reg [0:7];
  reg  [2:0]  req_reg;
  reg  [2:0]  mask_reg;
  reg  [31:0] supply_reg;
  reg         keySeen_reg;
  reg  [7:0]  prevYear_reg;
  reg         wakeSync1_reg;
  reg         wakeSync2_reg;
  reg         dPhase_reg;
  reg         dWrite_reg;
  reg  [7:0]  dAddr_reg;
  wire [1:0]  almHit;
  wire        centuryHit;
  wire        wrOk;
  wire [31:0] wrMaskT;
  wire [31:0] wrMaskD;
  reg  [31:0] rdNext;
  reg  [31:0] supply_next;
  integer     i;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gAlarm
      wire [31:0] t = almTime_reg[g];
      wire [31:0] d = almDate_reg[g];
      // Hour bits compared as stored; mode shared with calendar
      wire okSec  = !t[7]  || (t[6:0]   == liveTime[6:0]);
      wire okMin  = !t[15] || (t[14:8]  == liveTime[14:8]);
      wire okHour = !t[23] || (t[21:16] == liveTime[21:16]);
      wire okDay  = !t[31] || (t[26:24] == liveTime[26:24]);
      wire okMday = !d[7]  || (d[5:0]   == liveDate[5:0]);
      wire okMon  = !d[15] || (d[11:8]  == liveDate[11:8]);
      assign almHit[g] = secTick && d[31] && okSec && okMin && okHour &&
                         okDay && okMday && okMon;
    end
  endgenerate

  assign centuryHit = (prevYear_reg == 8'h99) &&
                      (liveDate[23:16] == 8'h00);

  assign wrOk = dPhase_reg && dWrite_reg;
  assign wrMaskT = `RTAC_TIME_MASK;
  assign wrMaskD = `RTAC_DATE_MASK;

  always @*
  begin
    supply_next = supply_reg;
    if (wrOk && dAddr_reg == `RTAC_OFF_SUPPLY)
    begin
      supply_next[`RTAC_SUP_KEY_LSB+7:`RTAC_SUP_KEY_LSB] = hwdata[7:0];
      supply_next[`RTAC_SUP_POL]   = hwdata[`RTAC_SUP_POL];
      supply_next[`RTAC_SUP_DRIVE] = hwdata[`RTAC_SUP_DRIVE];
      supply_next[`RTAC_SUP_FORCE] = supply_reg[`RTAC_SUP_FORCE] |
                                     hwdata[`RTAC_SUP_FORCE];
      // clear needs earlier key; set always allowed
      if (hwdata[`RTAC_SUP_EN])
        supply_next[`RTAC_SUP_EN] = 1'b1;
      else if (keySeen_reg && !supply_reg[`RTAC_SUP_FORCE])
        supply_next[`RTAC_SUP_EN] = 1'b0;
    end
    if ((|almHit) || centuryHit || wakeSync2_reg)
      supply_next[`RTAC_SUP_EN] = 1'b1;
  end

  always @*
  begin
    case (haddr)
      `RTAC_OFF_CTRL:    rdNext = ctrl_reg;
      `RTAC_OFF_STATUS:  rdNext = {31'h0000_0000, calBusy};
      `RTAC_OFF_TIME:    rdNext = ctrl_reg[`RTAC_CTRL_WRITE] ?
                                  usrTime_reg : frzTime_reg;
      `RTAC_OFF_DATE:    rdNext = ctrl_reg[`RTAC_CTRL_WRITE] ?
                                  usrDate_reg : frzDate_reg;
      `RTAC_OFF_A1TIME:  rdNext = almTime_reg[0];
      `RTAC_OFF_A1DATE:  rdNext = almDate_reg[0];
      `RTAC_OFF_A2TIME:  rdNext = almTime_reg[1];
      `RTAC_OFF_A2DATE:  rdNext = almDate_reg[1];
      `RTAC_OFF_REQ:     rdNext = {29'h0000_0000, req_reg};
      `RTAC_OFF_MASK:    rdNext = {29'h0000_0000, mask_reg};
      `RTAC_OFF_MASKED:  rdNext = {29'h0000_0000, req_reg & mask_reg};
      `RTAC_OFF_SUPPLY:  rdNext = supply_reg;
      default:
      begin
        if (haddr[7:5] == 3'b010)
          rdNext = scratch_reg[haddr[4:2]];
        else
          rdNext = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg      <= 32'h0000_0000;
      frzTime_reg   <= 32'h0000_0000;
      frzDate_reg   <= 32'h0000_0000;
      usrTime_reg   <= 32'h0000_0000;
      usrDate_reg   <= 32'h0000_0000;
      for (i = 0; i < 2; i = i + 1)
      begin
        almTime_reg[i] <= 32'h0000_0000;
        almDate_reg[i] <= 32'h0000_0000;
      end
      for (i = 0; i < 8; i = i + 1)
        scratch_reg[i] <= 32'h0000_0000;
      req_reg       <= 3'h0;
      mask_reg      <= 3'h0;
      supply_reg    <= `RTAC_SUP_RESET;
      keySeen_reg   <= 1'b0;
      prevYear_reg  <= 8'h00;
      wakeSync1_reg <= 1'b0;
      wakeSync2_reg <= 1'b0;
      dPhase_reg    <= 1'b0;
      dWrite_reg    <= 1'b0;
      dAddr_reg     <= 8'h00;
      hrdata        <= 32'h0000_0000;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      loadTime      <= 32'h0000_0000;
      loadDate      <= 32'h0000_0000;
      loadStrobe    <= 1'b0;
      supplyEnablePinOut <= 1'b1;
      supplyEnablePinOe  <= 1'b1;
      domainIrq     <= 1'b0;
      hibernateWake <= 1'b0;
      domainResetReq <= 1'b0;
    end
    else
    begin
      wakeSync1_reg <= wakeRequestPin;
      wakeSync2_reg <= wakeSync1_reg;
      prevYear_reg  <= liveDate[23:16];
      loadStrobe    <= 1'b0;
      domainResetReq <= 1'b0;
      dPhase_reg <= hsel && hready && htrans[1];
      dWrite_reg <= hwrite;
      dAddr_reg  <= haddr;
      if (hsel && hready && htrans[1] && !hwrite)
        hrdata <= rdNext;
      if (wrOk)
      begin
        case (dAddr_reg)
          `RTAC_OFF_CTRL:
          begin
            // read refused while busy or writing
            if (hwdata[`RTAC_CTRL_READ] && !ctrl_reg[`RTAC_CTRL_READ])
            begin
              if (!calBusy && !ctrl_reg[`RTAC_CTRL_WRITE])
              begin
                ctrl_reg[`RTAC_CTRL_READ] <= 1'b1;
                frzTime_reg <= liveTime;
                frzDate_reg <= liveDate;
              end
            end
            else if (!hwdata[`RTAC_CTRL_READ])
              ctrl_reg[`RTAC_CTRL_READ] <= 1'b0;
            if (hwdata[`RTAC_CTRL_WRITE] && !ctrl_reg[`RTAC_CTRL_WRITE])
            begin
              if (!calBusy && !ctrl_reg[`RTAC_CTRL_READ])
              begin
                ctrl_reg[`RTAC_CTRL_WRITE] <= 1'b1;
                usrTime_reg <= liveTime;
                usrDate_reg <= liveDate;
              end
            end
            else if (!hwdata[`RTAC_CTRL_WRITE] &&
                     ctrl_reg[`RTAC_CTRL_WRITE])
            begin
              // one-edge coherent copy to the calendar
              ctrl_reg[`RTAC_CTRL_WRITE] <= 1'b0;
              loadTime   <= usrTime_reg;
              loadDate   <= usrDate_reg;
              loadStrobe <= 1'b1;
            end
            ctrl_reg[`RTAC_CTRL_12H] <= hwdata[`RTAC_CTRL_12H];
          end
          // gated user writes; software follows handshake
          `RTAC_OFF_TIME:
            if (ctrl_reg[`RTAC_CTRL_WRITE])
              usrTime_reg <= hwdata;
          `RTAC_OFF_DATE:
            if (ctrl_reg[`RTAC_CTRL_WRITE])
              usrDate_reg <= hwdata;
          `RTAC_OFF_A1TIME:
            if (ctrl_reg[`RTAC_CTRL_WRITE])
              almTime_reg[0] <= hwdata & wrMaskT;
          `RTAC_OFF_A1DATE:
            if (ctrl_reg[`RTAC_CTRL_WRITE])
              almDate_reg[0] <= hwdata & wrMaskD;
          `RTAC_OFF_A2TIME:
            if (ctrl_reg[`RTAC_CTRL_WRITE])
              almTime_reg[1] <= hwdata & wrMaskT;
          `RTAC_OFF_A2DATE:
            if (ctrl_reg[`RTAC_CTRL_WRITE])
              almDate_reg[1] <= hwdata & wrMaskD;
          `RTAC_OFF_MASK:
            mask_reg <= hwdata[2:0];
          `RTAC_OFF_DOMRST:
            domainResetReq <= hwdata[`RTAC_DOMRST_BIT];
          default:
            if (dAddr_reg[7:5] == 3'b010)
              scratch_reg[dAddr_reg[4:2]] <= hwdata;
        endcase
      end
      // events set, write-one clears, set wins
      req_reg <= (req_reg & ~((wrOk && dAddr_reg == `RTAC_OFF_REQ) ?
                              hwdata[2:0] : 3'h0)) |
                 {centuryHit, almHit};
      supply_reg <= supply_next;
      // Key must be present in a write before the clearing one
      if (wrOk && dAddr_reg == `RTAC_OFF_SUPPLY)
        keySeen_reg <= (hwdata[7:0] == `RTAC_UNLOCK_KEY);
      supplyEnablePinOut <= supply_next[`RTAC_SUP_EN] ||
                            supply_next[`RTAC_SUP_FORCE];
      supplyEnablePinOe  <= supply_next[`RTAC_SUP_FORCE] ||
                            supply_next[`RTAC_SUP_DRIVE] ||
                            (supply_next[7:0] != `RTAC_UNLOCK_KEY);
      domainIrq <= |(req_reg & mask_reg);
      hibernateWake <= (hibernateAlarmWakeGate &&
                        |(req_reg[1:0] & mask_reg[1:0])) || wakeSync2_reg;
    end
  end

endmodule // rtac_alarm_supply
`default_nettype wire

// file: rtac_consts.vh
// Purpose: constants for the alarm and supply control block
// Assumes: AHB-Lite, 32-bit words, byte addresses below
// Notes:   offsets chosen for this block
`ifndef RTAC_CONSTS_VH
`define RTAC_CONSTS_VH
`define RTAC_OFF_CTRL     8'h00
`define RTAC_OFF_STATUS   8'h04
`define RTAC_OFF_TIME     8'h08
`define RTAC_OFF_DATE     8'h0C
`define RTAC_OFF_A1TIME   8'h10
`define RTAC_OFF_A1DATE   8'h14
`define RTAC_OFF_A2TIME   8'h18
`define RTAC_OFF_A2DATE   8'h1C
`define RTAC_OFF_REQ      8'h20
`define RTAC_OFF_MASK     8'h24
`define RTAC_OFF_MASKED   8'h28
`define RTAC_OFF_SUPPLY   8'h2C
`define RTAC_OFF_DOMRST   8'h30
`define RTAC_OFF_SCRATCH  8'h40
// Control bits
`define RTAC_CTRL_READ    0
`define RTAC_CTRL_WRITE   1
`define RTAC_CTRL_12H     2
// Time word: sec[6:0] en[7] min[14:8] en[15] hour[21:16] en[23]
// day[26:24] en[31]; date word: mday[5:0] en[7] mon[11:8] en[15]
// master enable at date bit 31; calendar date word year at [23:16]
`define RTAC_TIME_MASK    32'h87BF_FFFF
`define RTAC_DATE_MASK    32'h8000_8FBF
`define RTAC_YEAR_LSB     16
// Supply control fields
`define RTAC_SUP_KEY_LSB  0
`define RTAC_SUP_POL      16
`define RTAC_SUP_DRIVE    29
`define RTAC_SUP_FORCE    30
`define RTAC_SUP_EN       31
`define RTAC_UNLOCK_KEY   8'h3A
`define RTAC_SUP_RESET    32'hA001_0000
`define RTAC_DOMRST_BIT   31
// Event bits
`define RTAC_EV_A1        0
`define RTAC_EV_A2        1
`define RTAC_EV_CENT      2
`endif

// file: rtac_alarm_supply_asserts.sv
// Purpose: port checks for the alarm and supply block
// Assumes: zero-wait slave; updates land two or three edges after address
// Notes:   sees the block's ports only
`timescale 1ns/1ns
`default_nettype none
`include "rtac_consts.vh"
module rtac_alarm_supply_asserts
(
  // Clock, reset and bus
  input wire       clk_sys,
  input wire       rstn,
  input wire       hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire       hwrite,
  input wire       hready,
  input wire       hreadyout,
  input wire       hresp,
  // Pins and events
  input wire       loadStrobe,
  input wire       wakeRequestPin,
  input wire       hibernateAlarmWakeGate,
  input wire       supplyEnablePinOut,
  input wire       supplyEnablePinOe,
  input wire       domainIrq,
  input wire       hibernateWake,
  input wire       domainResetReq
);
  wire wrTaken = hsel & hready & htrans[1] & hwrite;
  wire supWr   = wrTaken & (haddr == `RTAC_OFF_SUPPLY);
  wire ctlWr   = wrTaken & (haddr == `RTAC_OFF_CTRL);
  wire rstWr   = wrTaken & (haddr == `RTAC_OFF_DOMRST);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_ready; hreadyout && !hresp; endproperty
  a_ready: assert property (p_ready)
    else $error("bus answer not ready or not okay");
  property p_load; loadStrobe |-> $past(ctlWr, 2) || $past(ctlWr, 3);
  endproperty
  a_load: assert property (p_load)
    else $error("load strobe without control write");
  property p_domrst;
    domainResetReq |-> ($past(rstWr, 2) || $past(rstWr, 3)) ##1 !domainResetReq;
  endproperty
  a_domrst: assert property (p_domrst)
    else $error("domain reset request not a single answered pulse");
  property p_enfall;
    $fell(supplyEnablePinOut) |-> $past(supWr, 2) || $past(supWr, 3);
  endproperty
  a_enfall: assert property (p_enfall)
    else $error("supply enable fell without supply write");
  property p_oefall;
    $fell(supplyEnablePinOe) |-> $past(supWr, 2) || $past(supWr, 3);
  endproperty
  a_oefall: assert property (p_oefall)
    else $error("pin drive fell without supply write");
  property p_wake; wakeRequestPin [*4] |-> ##[0:3] supplyEnablePinOut;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake request did not raise supply enable");
  property p_irqfall;
    $fell(domainIrq) |-> $past(wrTaken, 2) || $past(wrTaken, 3);
  endproperty
  a_irqfall: assert property (p_irqfall)
    else $error("interrupt fell without a write");
  property p_hwake;
    $rose(hibernateWake) |-> hibernateAlarmWakeGate ||
      $past(hibernateAlarmWakeGate) || $past(wakeRequestPin, 2) ||
      $past(wakeRequestPin, 3) || $past(wakeRequestPin, 4);
  endproperty
  a_hwake: assert property (p_hwake)
    else $error("hibernate wake without gate or wake pin");
endmodule // rtac_alarm_supply_asserts
`default_nettype wire

// file: rtac_supply_partner.sv
// Purpose: external regulator enable input
// Assumes: no pull on the enable net
// Notes:   an undriven net shows the inverse of its last level
`timescale 1ns/1ns
`default_nettype none
module rtac_supply_partner
(
  // Pin from the block
  input  wire logic pinOut,
  input  wire logic pinOe,
  // Regulator state
  output wire logic regOn
);
  logic lastLevel = 1'b1;
  // high enables, float gives the inverse of the last level
  assign regOn = pinOe ? pinOut : ~lastLevel;
  always @(pinOut or pinOe)
    if (pinOe)
      lastLevel = pinOut;
endmodule // rtac_supply_partner
`default_nettype wire

// file: tb.sv
// Purpose: bench for the alarm and supply block
// Assumes: zero-wait AHB-Lite slave
// Notes:   force-on runs last, it sticks until reset
`timescale 1ns/1ns
`default_nettype none
`include "rtac_consts.vh"
module tb;
  localparam logic [7:0] SUP = `RTAC_OFF_SUPPLY, REQ = `RTAC_OFF_REQ,
    CTL = `RTAC_OFF_CTRL, MSK = `RTAC_OFF_MASK, MSD = `RTAC_OFF_MASKED;
  logic        clk_sys = 0, rstn = 0, hwrite = 0, secTick = 0;
  logic [7:0]  haddr = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] hwdata = 0, liveTime = 0, liveDate = 32'h0025_0101;
  logic        wakeRequestPin = 0, hibernateAlarmWakeGate = 0, calBusy = 0;
  logic [31:0] hrdata, loadTime, loadDate, q;
  logic        hreadyout, hresp, loadStrobe, pinOut, pinOe, regOn;
  logic        domainIrq, hibernateWake, domainResetReq;
  int          mismatches = 0, samples_checked = 0;
  always #50 clk_sys = ~clk_sys;
  rtac_alarm_supply u_rtac_alarm_supply (.clk_sys(clk_sys), .rstn(rstn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .secTick(secTick),
    .liveTime(liveTime), .liveDate(liveDate), .calBusy(calBusy),
    .loadTime(loadTime), .loadDate(loadDate), .loadStrobe(loadStrobe),
    .wakeRequestPin(wakeRequestPin), .supplyEnablePinOut(pinOut),
    .hibernateAlarmWakeGate(hibernateAlarmWakeGate), .supplyEnablePinOe(pinOe),
    .domainIrq(domainIrq), .hibernateWake(hibernateWake),
    .domainResetReq(domainResetReq));
  rtac_supply_partner u_rtac_supply_partner (.pinOut(pinOut), .pinOe(pinOe),
    .regOn(regOn));
  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0000_0000);
    chk(n, e, q);
  endtask
  task automatic pin(input logic [1:0] e);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("pin oe,out", {30'b0, e}, {30'b0, pinOe, pinOut});
  endtask
  task automatic tick(input logic [31:0] t);
    liveTime <= t;
    @(posedge clk_sys);
    secTick <= 1'b1;
    @(posedge clk_sys);
    secTick <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic t_reset;
    rc("supply", SUP, `RTAC_SUP_RESET);
    rc("unmapped", 8'h3C, 32'h0000_0000);
    pin(2'b11);
  endtask
  task automatic t_unlock;
    wr(SUP, 32'h2001_0000);
    pin(2'b11);
    wr(SUP, 32'hA001_003A);
    wr(SUP, 32'h2001_003A);
    pin(2'b10);
    chk("regulator", 32'h0000_0000, {31'b0, regOn});
    wr(SUP, 32'hA001_003A);
    pin(2'b11);
    wr(SUP, 32'h2001_003A);
    wakeRequestPin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    wakeRequestPin <= 1'b0;
    pin(2'b11);
    wr(SUP, 32'h8001_003A);
    pin(2'b01);
    wr(SUP, 32'h8001_0000);
    pin(2'b11);
    wr(SUP, 32'hA001_0000);
  endtask
  task automatic t_alarm;
    wr(CTL, 32'h0000_0002);
    wr(`RTAC_OFF_A1TIME, 32'h0000_0085);
    wr(`RTAC_OFF_A1DATE, 32'h8000_0000);
    wr(`RTAC_OFF_A2TIME, 32'h0000_0000);
    wr(`RTAC_OFF_A2DATE, 32'h8000_0000);
    wr(CTL, 32'h0000_0000);
    wr(`RTAC_OFF_A1TIME, 32'h0000_0084);
    wr(MSK, 32'h0000_0001);
    tick(32'h0000_0004);
    rc("request", REQ, 32'h0000_0002);
    rc("masked", MSD, 32'h0000_0000);
    wr(REQ, 32'h0000_0007);
    wr(SUP, 32'hA001_003A);
    wr(SUP, 32'h2001_003A);
    tick(32'h0000_0005);
    rc("masked", MSD, 32'h0000_0001);
    pin(2'b11);
    chk("irq", 32'h0000_0001, {31'b0, domainIrq});
    chk("hib wake", 32'h0000_0000, {31'b0, hibernateWake});
    @(posedge clk_sys);
    hibernateAlarmWakeGate <= 1'b1;
    pin(2'b11);
    chk("hib wake", 32'h0000_0001, {31'b0, hibernateWake});
    @(posedge clk_sys);
    hibernateAlarmWakeGate <= 1'b0;
    wr(REQ, 32'h0000_0001);
    rc("request", REQ, 32'h0000_0002);
    chk("irq", 32'h0000_0000, {31'b0, domainIrq});
  endtask
  task automatic t_century;
    wr(CTL, 32'h0000_0002);
    wr(`RTAC_OFF_A2DATE, 32'h0000_0000);
    wr(CTL, 32'h0000_0000);
    wr(REQ, 32'h0000_0007);
    liveDate <= 32'h0099_0101;
    tick(32'h0000_0006);
    liveDate <= 32'h0000_0101;
    tick(32'h0000_0006);
    rc("request", REQ, 32'h0000_0004);
    chk("irq", 32'h0000_0000, {31'b0, domainIrq});
    wr(MSK, 32'h0000_0004);
    rc("masked", MSD, 32'h0000_0004);
    chk("irq", 32'h0000_0001, {31'b0, domainIrq});
  endtask
  task automatic t_freeze;
    calBusy <= 1'b1;
    wr(CTL, 32'h0000_0001);
    rc("status", `RTAC_OFF_STATUS, 32'h0000_0001);
    rc("ctrl", CTL, 32'h0000_0000);
    calBusy <= 1'b0;
    liveTime <= 32'h0011_2233;
    wr(CTL, 32'h0000_0001);
    liveTime <= 32'h0044_5566;
    rc("frozen", `RTAC_OFF_TIME, 32'h0011_2233);
    wr(CTL, 32'h0000_0003);
    rc("ctrl", CTL, 32'h0000_0001);
    wr(CTL, 32'h0000_0000);
    wr(CTL, 32'h0000_0002);
    wr(`RTAC_OFF_TIME, 32'h0007_0809);
    wr(CTL, 32'h0000_0000);
    #1;
    chk("load time", 32'h0007_0809, loadTime);
    chk("load date", 32'h0000_0101, loadDate);
    chk("load strobe", 32'h0000_0001, {31'b0, loadStrobe});
    @(posedge clk_sys);
    #1;
    chk("load strobe", 32'h0000_0000, {31'b0, loadStrobe});
  endtask
  task automatic t_scratch;
    for (int i = 0; i < 8; i++)
      wr(`RTAC_OFF_SCRATCH + 8'(4 * i), 32'h5A5A_0000 + 32'(i));
    for (int i = 0; i < 8; i++)
      rc("scratch", `RTAC_OFF_SCRATCH + 8'(4 * i), 32'h5A5A_0000 + 32'(i));
  endtask
  task automatic t_force;
    wr(SUP, 32'hA001_003A);
    wr(SUP, 32'hE001_003A);
    wr(SUP, 32'h4001_003A);
    pin(2'b11);
    wr(SUP, 32'hA001_003A);
    rc("force", SUP, 32'hE001_003A);
    wr(`RTAC_OFF_DOMRST, 32'h8000_0000);
    #1;
    chk("domain reset", 32'h0000_0001, {31'b0, domainResetReq});
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rc("supply", SUP, `RTAC_SUP_RESET);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_unlock();
    t_alarm();
    t_century();
    t_freeze();
    t_scratch();
    t_force();
    close_out();
  end
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    close_out();
  end
endmodule // tb
bind rtac_alarm_supply rtac_alarm_supply_asserts u_rtac_alarm_supply_asserts (
  .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .loadStrobe(loadStrobe), .wakeRequestPin(wakeRequestPin),
  .hibernateAlarmWakeGate(hibernateAlarmWakeGate),
  .supplyEnablePinOut(supplyEnablePinOut),
  .supplyEnablePinOe(supplyEnablePinOe), .domainIrq(domainIrq),
  .hibernateWake(hibernateWake), .domainResetReq(domainResetReq));
`default_nettype wire
